// >>> addr_gen_pkg.sv
// Behaviour
// - non-branch instructions advance the program counter by their byte length.
// - relative target is next address plus sign-extended 8-bit displacement, bit 7 sign.
// - short jump and every conditional branch use the relative target.
// - long call and long jump load the 16-bit immediate into the program counter.
// - fixed-area call targets always fall within 0800H to 0FFFH.
// - table vector call loads the entry selected by opcode bits 1 to 5 from 0040H-007FH.
// - register jump copies the accumulator pair into the program counter.
// - multiply uses accumulator and X, product goes to accumulator pair implicitly.
// - word divide reads dividend from and writes quotient to the accumulator pair.
// - decimal adjust and digit rotate implicitly use the accumulator.
// - register operands combine both bank-select flags with the 3-bit opcode code.
// - codes X,A,C,B,E,D,L,H map to registers 0-7; pairs map to 0-3.
// - direct addressing uses the 16-bit immediate unchanged as operand address.
// - short direct maps the 8-bit immediate onto FE20H through FF1FH.
// - short direct bit 8 is 0 for 20H-FFH and 1 for 00H-1FH.
// - in short direct only, FE20H-FEFFH selects high-speed RAM, FF00H-FF1FH selects special function registers.
package addr_gen_pkg;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 3;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [3:0] FIXED_TOP = 4'h0;
  localparam logic [6:0] SHORT_TOP = 7'h7f;
  localparam logic [7:0] SHORT_SFR_LIMIT = 8'h20;
  localparam int FIXED_BIT = 11;
  localparam int SIGN_BIT = 7;
  localparam int VEC_LO = 1;
  localparam int VEC_HI = 5;
  localparam logic [2:0] CODE_X = 3'h0;
  localparam logic [2:0] CODE_A = 3'h1;
  localparam logic [1:0] PAIR_AX = 2'h0;

  typedef enum logic [2:0] {
    PC_HOLD = 3'b000,
    PC_SEQ = 3'b001,
    PC_REL = 3'b010,
    PC_IMM16 = 3'b011,
    PC_FIXED = 3'b100,
    PC_TABLE = 3'b101,
    PC_PAIR = 3'b110
  } pc_op_e;

  typedef enum logic [2:0] {
    OPND_NONE = 3'b000,
    OPND_REG8 = 3'b001,
    OPND_REG16 = 3'b010,
    OPND_DIRECT = 3'b011,
    OPND_SHORT = 3'b100
  } opnd_mode_e;

  typedef enum logic [2:0] {
    IMPL_NONE = 3'b000,
    IMPL_MULTIPLY = 3'b001,
    IMPL_DIVIDE = 3'b010,
    IMPL_ADJUST_ADD = 3'b011,
    IMPL_ADJUST_SUB = 3'b100,
    IMPL_ROT_RIGHT = 3'b101,
    IMPL_ROT_LEFT = 3'b110
  } impl_op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_TABLE = 1'b1
  } pc_state_e;

  // absolute register number from bank flags and code
  function automatic logic [4:0] abs_reg(input logic bank_hi, input logic bank_lo, input logic [2:0] code);
    abs_reg = {bank_hi, bank_lo, code};
  endfunction
endpackage

// >>> cpu_address_generation.sv
`timescale 1ns/1ps
module cpu_address_generation (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // instruction from decoder
  input wire logic op_valid,
  input wire addr_gen_pkg::pc_op_e pc_op,
  input wire logic [2:0] instr_len,
  input wire logic [7:0] opcode,
  input wire logic [7:0] branch_displacement,
  input wire logic [15:0] imm16,
  input wire addr_gen_pkg::opnd_mode_e opnd_mode,
  input wire addr_gen_pkg::impl_op_e impl_op,
  input wire logic [2:0] reg_code,
  input wire logic [1:0] pair_code,
  // core state
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [15:0] accumulator_pair,
  // vector table read
  input wire logic table_valid,
  input wire logic [15:0] table_data,
  output logic table_req_q,
  output logic [15:0] table_addr_q,
  // program counter
  output logic busy_q,
  output logic [15:0] pc_q,
  output logic pc_load_q,
  // operand address
  output logic opnd_valid_q,
  output logic [15:0] opnd_addr_q,
  output logic ram_sel_q,
  output logic sfr_sel_q,
  output logic [4:0] reg_index_q,
  output logic [3:0] pair_index_q,
  // implied registers
  output logic impl_valid_q,
  output logic [4:0] impl_src_q,
  output logic [4:0] impl_aux_q,
  output logic [3:0] impl_pair_q,
  output logic impl_use_pair_q
);
  addr_gen_pkg::pc_state_e state_q;
  logic take;
  logic [15:0] next_seq;
  logic [15:0] rel_target;
  logic [15:0] fixed_target;
  logic [15:0] vec_addr;
  logic [15:0] pc_d;
  logic pc_upd;

  operand_if opi();

  assign opi.mode = opnd_mode;
  assign opi.imm16 = imm16;
  assign opi.imm8 = imm16[7:0];
  assign opi.bank_select_low = bank_select_low;
  assign opi.bank_select_high = bank_select_high;
  assign opi.reg_code = reg_code;
  assign opi.pair_code = pair_code;

  operand_addr_unit u_opnd (
    .op(opi.unit)
  );

  assign take = ce && op_valid && (state_q == addr_gen_pkg::ST_IDLE);
  assign next_seq = pc_q + {13'h0000, instr_len};
  assign rel_target = next_seq + {{8{branch_displacement[addr_gen_pkg::SIGN_BIT]}}, branch_displacement};
  assign fixed_target = {addr_gen_pkg::FIXED_TOP, 1'b1, imm16[10:0]};
  assign vec_addr = addr_gen_pkg::TABLE_BASE
                  | {10'h000, opcode[addr_gen_pkg::VEC_HI:addr_gen_pkg::VEC_LO], 1'b0};

  // next program counter
  always_comb begin
    pc_d = pc_q;
    pc_upd = 1'b0;
    case (pc_op)
      addr_gen_pkg::PC_SEQ: begin
        pc_d = next_seq;
        pc_upd = 1'b1;
      end
      addr_gen_pkg::PC_REL: begin
        pc_d = rel_target;
        pc_upd = 1'b1;
      end
      addr_gen_pkg::PC_IMM16: begin
        pc_d = imm16;
        pc_upd = 1'b1;
      end
      addr_gen_pkg::PC_FIXED: begin
        pc_d = fixed_target;
        pc_upd = 1'b1;
      end
      addr_gen_pkg::PC_PAIR: begin
        pc_d = accumulator_pair;
        pc_upd = 1'b1;
      end
      default: begin
        pc_d = pc_q;
        pc_upd = 1'b0;
      end
    endcase
  end

  // program counter and table sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= addr_gen_pkg::ST_IDLE;
      pc_q <= addr_gen_pkg::PC_RESET;
      pc_load_q <= 1'b0;
      table_req_q <= 1'b0;
      table_addr_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (ce) begin
      pc_load_q <= 1'b0;
      case (state_q)
        addr_gen_pkg::ST_IDLE: begin
          if (op_valid && pc_op == addr_gen_pkg::PC_TABLE) begin
            state_q <= addr_gen_pkg::ST_TABLE;
            table_req_q <= 1'b1;
            table_addr_q <= vec_addr;
            busy_q <= 1'b1;
          end else if (op_valid && pc_upd) begin
            pc_q <= pc_d;
            pc_load_q <= 1'b1;
          end
        end
        addr_gen_pkg::ST_TABLE: begin
          if (table_valid) begin
            pc_q <= table_data;
            pc_load_q <= 1'b1;
            table_req_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= addr_gen_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= addr_gen_pkg::ST_IDLE;
          table_req_q <= 1'b0;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // operand address capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opnd_valid_q <= 1'b0;
      opnd_addr_q <= 16'h0000;
      ram_sel_q <= 1'b0;
      sfr_sel_q <= 1'b0;
      reg_index_q <= 5'h00;
      pair_index_q <= 4'h0;
    end else if (ce) begin
      opnd_valid_q <= take && (opnd_mode != addr_gen_pkg::OPND_NONE);
      if (take) begin
        opnd_addr_q <= opi.addr;
        ram_sel_q <= opi.ram_sel;
        sfr_sel_q <= opi.sfr_sel;
        reg_index_q <= opi.reg_index;
        pair_index_q <= opi.pair_index;
      end
    end
  end

  // implied accumulator selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      impl_valid_q <= 1'b0;
      impl_src_q <= 5'h00;
      impl_aux_q <= 5'h00;
      impl_pair_q <= 4'h0;
      impl_use_pair_q <= 1'b0;
    end else if (ce) begin
      impl_valid_q <= take && (impl_op != addr_gen_pkg::IMPL_NONE);
      if (take) begin
        impl_pair_q <= {bank_select_high, bank_select_low, addr_gen_pkg::PAIR_AX};
        impl_src_q <= addr_gen_pkg::abs_reg(bank_select_high, bank_select_low, addr_gen_pkg::CODE_A);
        impl_aux_q <= addr_gen_pkg::abs_reg(bank_select_high, bank_select_low, addr_gen_pkg::CODE_X);
        case (impl_op)
          addr_gen_pkg::IMPL_MULTIPLY: begin
            impl_use_pair_q <= 1'b1;
          end
          addr_gen_pkg::IMPL_DIVIDE: begin
            impl_use_pair_q <= 1'b1;
          end
          default: begin
            impl_use_pair_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// >>> cpu_address_generation_props.sv
`timescale 1ns/1ps
module cpu_address_generation_props (
  // clock, control and instruction
  input wire logic clk, rst, ce, op_valid, table_valid, bank_select_low, bank_select_high,
  input wire addr_gen_pkg::pc_op_e pc_op,
  input wire addr_gen_pkg::opnd_mode_e opnd_mode,
  input wire logic [2:0] instr_len, reg_code,
  input wire logic [7:0] opcode, branch_displacement,
  input wire logic [15:0] imm16, accumulator_pair, table_data,
  // results
  input wire logic busy_q, pc_load_q, table_req_q, opnd_valid_q, ram_sel_q, sfr_sel_q,
  input wire logic [15:0] pc_q, table_addr_q, opnd_addr_q,
  input wire logic [4:0] reg_index_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = ce && op_valid && !busy_q;
  property p_seq;
    tk && pc_op == addr_gen_pkg::PC_SEQ |=> pc_load_q && pc_q == $past(pc_q) + 16'($past(instr_len));
  endproperty
  a_seq: assert property (p_seq) else $error("sequential advance wrong");
  property p_rel;
    tk && pc_op == addr_gen_pkg::PC_REL |=> pc_q == $past(pc_q) + 16'($past(instr_len))
      + {{8{$past(branch_displacement[7])}}, $past(branch_displacement)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_imm;
    tk && pc_op == addr_gen_pkg::PC_IMM16 |=> pc_q == $past(imm16);
  endproperty
  a_imm: assert property (p_imm) else $error("long jump target wrong");
  property p_fix;
    tk && pc_op == addr_gen_pkg::PC_FIXED |=> pc_q == {4'h0, 1'b1, $past(imm16[10:0])};
  endproperty
  a_fix: assert property (p_fix) else $error("fixed call target wrong");
  property p_pair;
    tk && pc_op == addr_gen_pkg::PC_PAIR |=> pc_q == $past(accumulator_pair);
  endproperty
  a_pair: assert property (p_pair) else $error("pair jump target wrong");
  sequence s_tab_go;
    tk && pc_op == addr_gen_pkg::PC_TABLE;
  endsequence
  sequence s_tab_wait;
    busy_q && table_req_q && table_addr_q == (16'h0040 | {10'h0, $past(opcode[5:1]), 1'b0});
  endsequence
  property p_tab;
    s_tab_go |=> s_tab_wait;
  endproperty
  a_tab: assert property (p_tab) else $error("vector fetch address wrong");
  property p_tab_load;
    busy_q && ce && table_valid |=> pc_load_q && !busy_q && pc_q == $past(table_data);
  endproperty
  a_tab_load: assert property (p_tab_load) else $error("vector entry not loaded");
  property p_refuse;
    busy_q && !table_valid |=> $stable(pc_q) && !pc_load_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("pc moved while waiting");
  property p_dir;
    tk && opnd_mode == addr_gen_pkg::OPND_DIRECT |=> opnd_valid_q && opnd_addr_q == $past(imm16);
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_short;
    tk && opnd_mode == addr_gen_pkg::OPND_SHORT |=> opnd_valid_q && ram_sel_q != sfr_sel_q
      && sfr_sel_q == ($past(imm16[7:0]) < 8'h20)
      && opnd_addr_q == {7'h7f, $past(imm16[7:0]) < 8'h20, $past(imm16[7:0])};
  endproperty
  a_short: assert property (p_short) else $error("short address wrong");
  property p_reg;
    tk |=> reg_index_q == {$past(bank_select_high), $past(bank_select_low), $past(reg_code)};
  endproperty
  a_reg: assert property (p_reg) else $error("register index wrong");
endmodule

bind cpu_address_generation cpu_address_generation_props i_props (.clk, .rst, .ce, .op_valid, .table_valid,
  .bank_select_low, .bank_select_high, .pc_op, .opnd_mode, .instr_len, .reg_code, .opcode, .branch_displacement,
  .imm16, .accumulator_pair, .table_data, .busy_q, .pc_load_q, .table_req_q, .opnd_valid_q, .ram_sel_q,
  .sfr_sel_q, .pc_q, .table_addr_q, .opnd_addr_q, .reg_index_q);

// >>> cpu_address_generation_tb.sv
`timescale 1ns/1ps
module cpu_address_generation_tb;
  logic clk = 0, rst = 1, ce = 1, op_valid = 0, table_valid = 0, bank_select_low = 0, bank_select_high = 0;
  addr_gen_pkg::pc_op_e pc_op = addr_gen_pkg::PC_HOLD;
  addr_gen_pkg::opnd_mode_e opnd_mode = addr_gen_pkg::OPND_NONE;
  addr_gen_pkg::impl_op_e impl_op = addr_gen_pkg::IMPL_NONE;
  logic [2:0] instr_len = 3'h1, reg_code = 3'h0;
  logic [1:0] pair_code = 2'h0;
  logic [7:0] opcode = 8'h00, branch_displacement = 8'h00;
  logic [15:0] imm16 = 16'h0000, accumulator_pair = 16'h0000, table_data = 16'h0000, m_pc = 16'h0000;
  logic busy_q, pc_load_q, table_req_q, opnd_valid_q, ram_sel_q, sfr_sel_q, impl_valid_q, impl_use_pair_q;
  logic [15:0] pc_q, table_addr_q, opnd_addr_q;
  logic [4:0] reg_index_q, impl_src_q, impl_aux_q;
  logic [3:0] pair_index_q, impl_pair_q;
  logic [31:0] pcq[$], oaq[$], imq[$], e_note;
  int err_count = 0, checks = 0;
  always #5 clk = ~clk;
  cpu_address_generation i_dut (.clk, .rst, .ce, .op_valid, .pc_op, .instr_len, .opcode, .branch_displacement,
    .imm16, .opnd_mode, .impl_op, .reg_code, .pair_code, .bank_select_low, .bank_select_high, .accumulator_pair,
    .table_valid, .table_data, .table_req_q, .table_addr_q, .busy_q, .pc_q, .pc_load_q, .opnd_valid_q,
    .opnd_addr_q, .ram_sel_q, .sfr_sel_q, .reg_index_q, .pair_index_q, .impl_valid_q, .impl_src_q, .impl_aux_q,
    .impl_pair_q, .impl_use_pair_q);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // results pair with the oldest note; an unexpected result meets all ones
  always @(posedge clk) begin
    #2;
    if (pc_load_q !== 1'b0) begin
      e_note = pcq.size() ? pcq.pop_front() : 32'hffffffff;
      chk("pc", {16'h0000, pc_q}, e_note);
    end
    if (opnd_valid_q !== 1'b0) begin
      e_note = oaq.size() ? oaq.pop_front() : 32'hffffffff;
      chk("opnd", {5'h00, opnd_addr_q, ram_sel_q, sfr_sel_q, pair_index_q, reg_index_q}, e_note);
    end
    if (impl_valid_q !== 1'b0) begin
      e_note = imq.size() ? imq.pop_front() : 32'hffffffff;
      chk("impl", {11'h000, impl_pair_q, impl_use_pair_q, impl_aux_q, impl_src_q}, e_note);
    end
  end
  task automatic issue(input addr_gen_pkg::pc_op_e p);
    logic [15:0] nxt;
    logic [15:0] oa;
    logic [31:0] ev;
    logic lo;
    op_valid = 1;
    pc_op = p;
    instr_len = 3'($urandom_range(4, 1));
    branch_displacement = 8'($urandom);
    imm16 = 16'($urandom);
    opcode = 8'($urandom);
    accumulator_pair = 16'($urandom);
    opnd_mode = addr_gen_pkg::opnd_mode_e'($urandom_range(4, 0));
    impl_op = addr_gen_pkg::impl_op_e'($urandom_range(6, 0));
    {bank_select_high, bank_select_low, reg_code} = 5'($urandom);
    pair_code = 2'($urandom);
    case (p)
      addr_gen_pkg::PC_SEQ: nxt = m_pc + 16'(instr_len);
      addr_gen_pkg::PC_REL: nxt = m_pc + 16'(instr_len) + {{8{branch_displacement[7]}}, branch_displacement};
      addr_gen_pkg::PC_IMM16: nxt = imm16;
      addr_gen_pkg::PC_FIXED: nxt = {4'h0, 1'b1, imm16[10:0]};
      addr_gen_pkg::PC_PAIR: nxt = accumulator_pair;
      default: nxt = m_pc;
    endcase
    // every taken pc update pulses the load flag, even to the same value
    if (p inside {addr_gen_pkg::PC_SEQ, addr_gen_pkg::PC_REL, addr_gen_pkg::PC_IMM16, addr_gen_pkg::PC_FIXED,
      addr_gen_pkg::PC_PAIR}) pcq.push_back({16'h0000, nxt});
    m_pc = nxt;
    lo = (imm16[7:0] < 8'h20);
    oa = (opnd_mode == addr_gen_pkg::OPND_DIRECT) ? imm16 : 16'h0000;
    if (opnd_mode == addr_gen_pkg::OPND_SHORT) oa = {7'h7f, lo, imm16[7:0]};
    if (opnd_mode != addr_gen_pkg::OPND_NONE) oaq.push_back({5'h00, oa,
      (opnd_mode == addr_gen_pkg::OPND_SHORT) && !lo, (opnd_mode == addr_gen_pkg::OPND_SHORT) && lo,
      bank_select_high, bank_select_low, pair_code,
      bank_select_high, bank_select_low, reg_code});
    if (impl_op != addr_gen_pkg::IMPL_NONE) imq.push_back({11'h000, bank_select_high, bank_select_low, 2'h0,
      impl_op inside {addr_gen_pkg::IMPL_MULTIPLY, addr_gen_pkg::IMPL_DIVIDE}, bank_select_high,
      bank_select_low, 3'h0, bank_select_high, bank_select_low, 3'h1});
    @(posedge clk);
    #1;
    if (p == addr_gen_pkg::PC_TABLE) begin
      ev = {16'h0003, 16'h0040 | {10'h000, opcode[5:1], 1'b0}};
      chk("vector", {14'h0000, table_req_q, busy_q, table_addr_q}, ev);
      // a request offered while waiting must be ignored
      pc_op = addr_gen_pkg::PC_SEQ;
      repeat ($urandom_range(3, 0)) begin
        @(posedge clk);
        #1;
      end
      table_valid = 1;
      table_data = 16'($urandom);
      pcq.push_back({16'h0000, table_data});
      m_pc = table_data;
      @(posedge clk);
      #1;
      table_valid = 0;
      op_valid = 0;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3fb7));
    repeat (4) @(posedge clk);
    #1 rst = 0;
    repeat (400) issue(addr_gen_pkg::pc_op_e'($urandom_range(6, 0)));
    // let result pulses drop first, a frozen pulse would read as a new result
    op_valid = 0;
    @(posedge clk);
    // clock enable low freezes everything
    #1 ce = 0;
    op_valid = 1;
    pc_op = addr_gen_pkg::PC_PAIR;
    repeat (3) @(posedge clk);
    #1 ce = 1;
    op_valid = 0;
    chk("freeze", {16'h0000, pc_q}, {16'h0000, m_pc});
    repeat (4) @(posedge clk);
    #1 chk("drain", 32'(pcq.size() + oaq.size() + imq.size()), 32'h0);
    complete_run;
  end
endmodule

// >>> operand_addr_unit.sv
`timescale 1ns/1ps
module operand_addr_unit (
  operand_if.unit op
);
  logic short_hi;

  assign short_hi = (op.imm8 < addr_gen_pkg::SHORT_SFR_LIMIT);

  always_comb begin
    op.addr = 16'h0000;
    op.ram_sel = 1'b0;
    op.sfr_sel = 1'b0;
    case (op.mode)
      addr_gen_pkg::OPND_DIRECT: begin
        op.addr = op.imm16;
      end
      addr_gen_pkg::OPND_SHORT: begin
        op.addr = {addr_gen_pkg::SHORT_TOP, short_hi, op.imm8};
        op.ram_sel = ~short_hi;
        op.sfr_sel = short_hi;
      end
      default: begin
        op.addr = 16'h0000;
      end
    endcase
  end

  assign op.reg_index = addr_gen_pkg::abs_reg(op.bank_select_high, op.bank_select_low, op.reg_code);
  assign op.pair_index = {op.bank_select_high, op.bank_select_low, op.pair_code};
endmodule

// >>> operand_if.sv
`timescale 1ns/1ps
interface operand_if;
  addr_gen_pkg::opnd_mode_e mode;
  logic [15:0] imm16;
  logic [7:0] imm8;
  logic bank_select_low;
  logic bank_select_high;
  logic [2:0] reg_code;
  logic [1:0] pair_code;
  logic [15:0] addr;
  logic ram_sel;
  logic sfr_sel;
  logic [4:0] reg_index;
  logic [3:0] pair_index;

  modport unit (
    input mode, imm16, imm8, bank_select_low, bank_select_high, reg_code, pair_code,
    output addr, ram_sel, sfr_sel, reg_index, pair_index
  );
  modport user (
    output mode, imm16, imm8, bank_select_low, bank_select_high, reg_code, pair_code,
    input addr, ram_sel, sfr_sel, reg_index, pair_index
  );
endinterface
